// *** src/csbu_top.sv ***
// compare, skip and branch execution unit behind an AXI4-Lite slave
// assumes software loads operands, flags and pc, then writes the opcode
//
// Functional notes
// RULE_01: compare immediate sets flags, keeps register
// RULE_02: register bit clear skips next instruction
// RULE_03: register bit set skips next instruction
// RULE_04: io bit clear skips next instruction
// RULE_05: io bit set skips next instruction
// RULE_06: selected flag set branches to pc+k+1
// RULE_07: selected flag clear branches to pc+k+1
// RULE_08: equal on zero set, not equal clear
// RULE_09: carry set or lower on carry one
// RULE_10: minus on negative set, plus clear
// RULE_11: signed greater-equal when negative xor overflow zero
// RULE_12: signed less-than when negative xor overflow one
// RULE_13: half carry set and clear branches
// RULE_14: compare with carry keeps zero cleared-only
// RULE_15: branch 1/2 cycles, skip 1/2/3, flags kept
`timescale 1ns/1ps
`default_nettype none

module csbu_top
  import csbu_pkg::*;
(
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // axi write address
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [7:0]  s_axi_awaddr_i,
  // axi write data
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  // axi write response
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  output logic      [1:0]  s_axi_bresp_o,
  // axi read address
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  input  wire logic [7:0]  s_axi_araddr_i,
  // axi read data
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  output logic      [31:0] s_axi_rdata_o,
  output logic      [1:0]  s_axi_rresp_o,
  // core state
  output logic      [15:0] pc_o,
  output logic      [7:0]  flags_o,
  output logic             busy_o
);

  // ****************************************
  // state
  // ****************************************
  logic [15:0] pc_q;
  logic [7:0]  flags_q;
  logic [31:0] opd_q;
  logic [4:0]  op_q;
  logic [2:0]  sel_q;
  logic        busy_q;
  logic [1:0]  cnt_q;
  logic        taken_q;
  logic [1:0]  last_cyc_q;
  logic        aw_q, w_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;

  // operand views
  logic [7:0]  dst_w, src_w;
  logic [15:0] ofs_w;
  logic        two_w;
  logic [5:0]  alu_flags;
  logic        is_cmp, is_skip, taken_w, commit_w, wr_go;
  logic [1:0]  cyc_w;
  logic [15:0] pc_next_w;

  assign dst_w = opd_q[CSBU_OPD_DST_LSB +: 8];
  assign src_w = opd_q[CSBU_OPD_SRC_LSB +: 8];
  assign ofs_w = {{9{opd_q[CSBU_OPD_OFS_LSB + 6]}},
                  opd_q[CSBU_OPD_OFS_LSB +: 7]};
  assign two_w = opd_q[CSBU_OPD_TWO_BIT];

  // ****************************************
  // decode
  // ****************************************
  // fixed-flag branches are the generic test with a preset flag and sense
  function automatic logic branch_cond(input logic [4:0] op,
                                       input logic [2:0] sel,
                                       input logic [7:0] f);
    logic nv;
    nv = f[CSBU_FLG_N] ^ f[CSBU_FLG_V];
    case (op)
      CSBU_OP_BRANCH_STATUS_BIT_SET:   branch_cond = f[sel];    // [RULE_06]
      CSBU_OP_BRANCH_STATUS_BIT_CLEAR: branch_cond = ~f[sel];   // [RULE_07]
      CSBU_OP_BRANCH_EQUAL:      branch_cond = f[CSBU_FLG_Z];   // [RULE_08]
      CSBU_OP_BRANCH_NOT_EQUAL:  branch_cond = ~f[CSBU_FLG_Z];  // [RULE_08]
      CSBU_OP_BRANCH_CARRY_SET,
      CSBU_OP_BRANCH_LOWER:      branch_cond = f[CSBU_FLG_C];   // [RULE_09]
      CSBU_OP_BRANCH_CARRY_CLEAR,
      CSBU_OP_BRANCH_SAME_OR_HIGHER:
                                 branch_cond = ~f[CSBU_FLG_C];  // [RULE_09]
      CSBU_OP_BRANCH_MINUS:      branch_cond = f[CSBU_FLG_N];   // [RULE_10]
      CSBU_OP_BRANCH_PLUS:       branch_cond = ~f[CSBU_FLG_N];  // [RULE_10]
      CSBU_OP_BRANCH_SIGNED_GE:  branch_cond = ~nv;             // [RULE_11]
      CSBU_OP_BRANCH_SIGNED_LT:  branch_cond = nv;              // [RULE_12]
      CSBU_OP_BRANCH_HALF_CARRY_SET:
                                 branch_cond = f[CSBU_FLG_H];   // [RULE_13]
      CSBU_OP_BRANCH_HALF_CARRY_CLEAR:
                                 branch_cond = ~f[CSBU_FLG_H];  // [RULE_13]
      default:                   branch_cond = 1'b0;
    endcase
  endfunction

  // skip test: register and io forms both look at the source byte
  always_comb begin
    is_cmp  = (op_q == CSBU_OP_COMPARE_IMMEDIATE)
            | (op_q == CSBU_OP_COMPARE_WITH_CARRY);
    is_skip = (op_q >= CSBU_OP_SKIP_REG_BIT_CLEAR)
            & (op_q <= CSBU_OP_SKIP_IO_BIT_SET);
    case (op_q)
      CSBU_OP_SKIP_REG_BIT_CLEAR: taken_w = ~src_w[sel_q];  // [RULE_02]
      CSBU_OP_SKIP_REG_BIT_SET:   taken_w = src_w[sel_q];   // [RULE_03]
      CSBU_OP_SKIP_IO_BIT_CLEAR:  taken_w = ~src_w[sel_q];  // [RULE_04]
      CSBU_OP_SKIP_IO_BIT_SET:    taken_w = src_w[sel_q];   // [RULE_05]
      default: taken_w = branch_cond(op_q, sel_q, flags_q);
    endcase
    if (is_cmp || !taken_w) begin
      cyc_w     = CSBU_CYC_ONE;
      pc_next_w = pc_q + 16'h0001;
    end else if (is_skip) begin
      cyc_w     = two_w ? CSBU_CYC_THREE : CSBU_CYC_TWO;    // [RULE_15]
      pc_next_w = pc_q + (two_w ? 16'h0003 : 16'h0002);
    end else begin
      cyc_w     = CSBU_CYC_TWO;                             // [RULE_15]
      pc_next_w = pc_q + ofs_w + 16'h0001;
    end
  end

  csbu_cmp_alu u_alu (
    .dst_i   (dst_w),
    .src_i   (src_w),
    .carry_i (flags_q[CSBU_FLG_C]),
    .zero_i  (flags_q[CSBU_FLG_Z]),
    .chain_i (op_q == CSBU_OP_COMPARE_WITH_CARRY),          // [RULE_14]
    .flags_o (alu_flags)
  );

  // ****************************************
  // axi write path
  // ****************************************
  assign wr_go    = aw_q & w_q & ~s_axi_bvalid_o;
  assign commit_w = busy_q & (cnt_q == CSBU_CYC_ONE);

  // address and data are taken independently, answered once both held
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      aw_q <= 1'b0;
      w_q  <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= CSBU_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q  <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        // writes during execution are refused to keep operands stable
        s_axi_bresp_o  <= (busy_q || awaddr_q > CSBU_OFS_PC
                           || awaddr_q[1:0] != 2'h0)
                          ? CSBU_RESP_SLV : CSBU_RESP_OKAY;
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  assign s_axi_awready_o = ~aw_q & ~s_axi_bvalid_o;
  assign s_axi_wready_o  = ~w_q & ~s_axi_bvalid_o;

  // ****************************************
  // execution and architectural state
  // ****************************************
  // besides flags register writes, flags only change at commit of a compare; skips and branches keep them
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pc_q <= CSBU_PC_RST;
      flags_q <= CSBU_FLAGS_RST;
      opd_q <= 32'h0000_0000;
      op_q <= 5'h00;
      sel_q <= 3'h0;
      busy_q <= 1'b0;
      cnt_q <= 2'h0;
      taken_q <= 1'b0;
      last_cyc_q <= 2'h0;
    end else if (wr_go && !busy_q) begin
      case (awaddr_q)
        CSBU_OFS_INSTR: begin
          if (wstrb_q[0]) begin
            op_q   <= wdata_q[CSBU_INSTR_OP_LSB +: 5];
            busy_q <= 1'b1;
            cnt_q  <= 2'h0;
          end
          if (wstrb_q[1]) sel_q <= wdata_q[CSBU_INSTR_SEL_LSB +: 3];
        end
        CSBU_OFS_OPERAND: begin
          for (int i = 0; i < 4; i++) begin
            if (wstrb_q[i]) opd_q[8*i +: 8] <= wdata_q[8*i +: 8];
          end
        end
        CSBU_OFS_FLAGS: if (wstrb_q[0]) flags_q <= wdata_q[7:0];
        CSBU_OFS_PC: begin
          if (wstrb_q[0]) pc_q[7:0]  <= wdata_q[7:0];
          if (wstrb_q[1]) pc_q[15:8] <= wdata_q[15:8];
        end
        default: ;
      endcase
    end else if (busy_q && cnt_q == 2'h0) begin
      // first busy cycle: operands are stable, fix the cycle count
      // this cycle already counts, so the counter holds the rest
      cnt_q   <= cyc_w - 2'h1;
      taken_q <= taken_w & ~is_cmp;
      last_cyc_q <= cyc_w;
      if (cyc_w == CSBU_CYC_ONE) begin
        busy_q <= 1'b0;
        pc_q   <= pc_next_w;
        if (is_cmp) flags_q[5:0] <= alu_flags;          // [RULE_01] [RULE_14]
      end
    end else if (busy_q) begin
      cnt_q <= cnt_q - 2'h1;
      if (commit_w) begin
        busy_q <= 1'b0;
        pc_q   <= pc_next_w;                             // [RULE_15]
      end
    end
  end

  // ****************************************
  // axi read path
  // ****************************************
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0000_0000;
      s_axi_rresp_o  <= CSBU_RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o  <= CSBU_RESP_OKAY;
      case (s_axi_araddr_i)
        CSBU_OFS_INSTR:   s_axi_rdata_o <= {21'h000000, sel_q, 3'h0, op_q};
        CSBU_OFS_OPERAND: s_axi_rdata_o <= opd_q;
        CSBU_OFS_FLAGS:   s_axi_rdata_o <= {24'h000000, flags_q};
        CSBU_OFS_PC:      s_axi_rdata_o <= {16'h0000, pc_q};
        CSBU_OFS_STATUS:  s_axi_rdata_o <= {28'h0000000, last_cyc_q,
                                            taken_q, busy_q};
        default: begin
          s_axi_rdata_o <= 32'h0000_0000;
          s_axi_rresp_o <= CSBU_RESP_SLV;
        end
      endcase
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  assign s_axi_arready_o = ~s_axi_rvalid_o;
  assign pc_o    = pc_q;
  assign flags_o = flags_q;
  assign busy_o  = busy_q;

  // ****************************************
  // checks
  // ****************************************
  logic eval_w;
  assign eval_w = busy_q & (cnt_q == 2'h0);

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  AST_CPI_FLAGS: assert property (eval_w                       // [RULE_01]
    && op_q == CSBU_OP_COMPARE_IMMEDIATE |=> !busy_q
    && flags_q[CSBU_FLG_Z] == ($past(dst_w) == $past(src_w))
    && pc_q == $past(pc_q) + 16'h0001)
    else $error("compare immediate result wrong");
  AST_SKRC: assert property (eval_w                            // [RULE_02]
    && op_q == CSBU_OP_SKIP_REG_BIT_CLEAR && !src_w[sel_q] && !two_w
    |=> busy_q ##1 !busy_q && pc_q == $past(pc_q, 2) + 16'h0002)
    else $error("register clear skip wrong");
  AST_SKRS: assert property (eval_w                            // [RULE_03]
    && op_q == CSBU_OP_SKIP_REG_BIT_SET && src_w[sel_q] && two_w
    |=> busy_q[*2] ##1 !busy_q && pc_q == $past(pc_q, 3) + 16'h0003)
    else $error("register set skip wrong");
  AST_SKIC: assert property (eval_w                            // [RULE_04]
    && op_q == CSBU_OP_SKIP_IO_BIT_CLEAR && src_w[sel_q]
    |=> !busy_q && pc_q == $past(pc_q) + 16'h0001)
    else $error("io clear skip taken wrongly");
  AST_SKIS: assert property (eval_w                            // [RULE_05]
    && op_q == CSBU_OP_SKIP_IO_BIT_SET && !src_w[sel_q]
    |=> !busy_q && pc_q == $past(pc_q) + 16'h0001)
    else $error("io set skip taken wrongly");
  AST_BRANCH_STATUS_BIT_SET: assert property (eval_w                            // [RULE_06]
    && op_q == CSBU_OP_BRANCH_STATUS_BIT_SET && flags_q[sel_q]
    |-> ##2 pc_q == $past(pc_q, 2) + $past(ofs_w, 2) + 16'h0001)
    else $error("flag set branch target wrong");
  AST_BRANCH_STATUS_BIT_CLEAR: assert property (eval_w                            // [RULE_07]
    && op_q == CSBU_OP_BRANCH_STATUS_BIT_CLEAR |-> taken_w == !flags_q[sel_q])
    else $error("flag clear branch decision wrong");
  AST_BEQ: assert property (eval_w && op_q == CSBU_OP_BRANCH_EQUAL // [RULE_08]
    |-> taken_w == flags_q[CSBU_FLG_Z])
    else $error("equal branch decision wrong");
  AST_BLO: assert property (eval_w && op_q == CSBU_OP_BRANCH_LOWER // [RULE_09]
    |=> taken_q == $past(flags_q[CSBU_FLG_C]))
    else $error("lower branch decision wrong");
  AST_BPL: assert property (eval_w && op_q == CSBU_OP_BRANCH_PLUS // [RULE_10]
    && !flags_q[CSBU_FLG_N] |=> busy_q ##1 !busy_q)
    else $error("plus branch timing wrong");
  AST_BGE: assert property (eval_w                             // [RULE_11]
    && op_q == CSBU_OP_BRANCH_SIGNED_GE
    |-> taken_w == !(flags_q[CSBU_FLG_N] ^ flags_q[CSBU_FLG_V]))
    else $error("signed ge decision wrong");
  AST_BLT: assert property (eval_w                             // [RULE_12]
    && op_q == CSBU_OP_BRANCH_SIGNED_LT
    |-> taken_w == (flags_q[CSBU_FLG_N] ^ flags_q[CSBU_FLG_V]))
    else $error("signed lt decision wrong");
  AST_BHC: assert property (eval_w                             // [RULE_13]
    && op_q == CSBU_OP_BRANCH_HALF_CARRY_CLEAR && flags_q[CSBU_FLG_H]
    |=> !busy_q && !taken_q)
    else $error("half carry clear branch taken wrongly");
  AST_CPC_Z: assert property (eval_w                           // [RULE_14]
    && op_q == CSBU_OP_COMPARE_WITH_CARRY && !flags_q[CSBU_FLG_Z]
    |=> !flags_q[CSBU_FLG_Z])
    else $error("compare with carry raised zero");
  AST_FLAGS_KEPT: assert property (eval_w && !is_cmp           // [RULE_15]
    |=> $stable(flags_q) [*3])
    else $error("skip or branch changed flags");
  AST_NOT_TAKEN_1: assert property (eval_w && !is_cmp && !taken_w // [RULE_15]
    |=> !busy_q)
    else $error("untaken instruction took more than one cycle");

  COV_BRANCH_TAKEN: cover property (eval_w && !is_cmp && !is_skip && taken_w);
  COV_SKIP_TWO: cover property (eval_w && is_skip && taken_w && two_w);
  COV_CPC: cover property (eval_w && op_q == CSBU_OP_COMPARE_WITH_CARRY);
  COV_REFUSED: cover property (wr_go && busy_q);

endmodule // csbu_top

`default_nettype wire

// *** src/csbu_pkg.sv ***
// package for the compare, skip and branch unit
// assumes a 32-bit AXI4-Lite register bus and one 100 MHz core clock
package csbu_pkg;

  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [7:0] CSBU_OFS_INSTR   = 8'h00;
  localparam logic [7:0] CSBU_OFS_OPERAND = 8'h04;
  localparam logic [7:0] CSBU_OFS_FLAGS   = 8'h08;
  localparam logic [7:0] CSBU_OFS_PC      = 8'h0C;
  localparam logic [7:0] CSBU_OFS_STATUS  = 8'h10;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CSBU_INSTR_OP_LSB  = 0;   // opcode [4:0]
  localparam int CSBU_INSTR_SEL_LSB = 8;   // bit or flag select [10:8]
  localparam int CSBU_OPD_DST_LSB   = 0;   // destination value [7:0]
  localparam int CSBU_OPD_SRC_LSB   = 8;   // source / constant / io [15:8]
  localparam int CSBU_OPD_OFS_LSB   = 16;  // signed branch offset [22:16]
  localparam int CSBU_OPD_TWO_BIT   = 24;  // next instruction is two words

  // status flag positions
  localparam int CSBU_FLG_C = 0;
  localparam int CSBU_FLG_Z = 1;
  localparam int CSBU_FLG_N = 2;
  localparam int CSBU_FLG_V = 3;
  localparam int CSBU_FLG_S = 4;
  localparam int CSBU_FLG_H = 5;

  // ****************************************
  // reset values and cycle counts
  // ****************************************
  localparam logic [7:0]  CSBU_FLAGS_RST = 8'h00;
  localparam logic [15:0] CSBU_PC_RST    = 16'h0000;
  localparam logic [1:0]  CSBU_CYC_ONE   = 2'h1;
  localparam logic [1:0]  CSBU_CYC_TWO   = 2'h2;
  localparam logic [1:0]  CSBU_CYC_THREE = 2'h3;
  localparam logic [1:0]  CSBU_RESP_OKAY = 2'h0;
  localparam logic [1:0]  CSBU_RESP_SLV  = 2'h2;

  // ****************************************
  // opcodes
  // ****************************************
  typedef enum logic [4:0] {
    CSBU_OP_COMPARE_IMMEDIATE       = 5'h00,
    CSBU_OP_COMPARE_WITH_CARRY      = 5'h01,
    CSBU_OP_SKIP_REG_BIT_CLEAR      = 5'h02,
    CSBU_OP_SKIP_REG_BIT_SET        = 5'h03,
    CSBU_OP_SKIP_IO_BIT_CLEAR       = 5'h04,
    CSBU_OP_SKIP_IO_BIT_SET         = 5'h05,
    CSBU_OP_BRANCH_STATUS_BIT_SET   = 5'h06,
    CSBU_OP_BRANCH_STATUS_BIT_CLEAR = 5'h07,
    CSBU_OP_BRANCH_EQUAL            = 5'h08,
    CSBU_OP_BRANCH_NOT_EQUAL        = 5'h09,
    CSBU_OP_BRANCH_CARRY_SET        = 5'h0A,
    CSBU_OP_BRANCH_CARRY_CLEAR      = 5'h0B,
    CSBU_OP_BRANCH_SAME_OR_HIGHER   = 5'h0C,
    CSBU_OP_BRANCH_LOWER            = 5'h0D,
    CSBU_OP_BRANCH_MINUS            = 5'h0E,
    CSBU_OP_BRANCH_PLUS             = 5'h0F,
    CSBU_OP_BRANCH_SIGNED_GE        = 5'h10,
    CSBU_OP_BRANCH_SIGNED_LT        = 5'h11,
    CSBU_OP_BRANCH_HALF_CARRY_SET   = 5'h12,
    CSBU_OP_BRANCH_HALF_CARRY_CLEAR = 5'h13
  } csbu_op_e;

endpackage : csbu_pkg

// *** src/csbu_cmp_alu.sv ***
// subtract-only flag generator for the compare instructions
// assumes operands held stable by the caller; purely combinational
`timescale 1ns/1ps
`default_nettype none

module csbu_cmp_alu
  import csbu_pkg::*;
(
  // operands
  input  wire logic [7:0] dst_i,
  input  wire logic [7:0] src_i,
  input  wire logic       carry_i,
  input  wire logic       zero_i,
  input  wire logic       chain_i,
  // flags out
  output logic      [5:0] flags_o
);

  logic [8:0] diff;
  logic [7:0] r;

  // ****************************************
  // difference and flags
  // ****************************************
  // the difference is only used for flags, never written back
  always_comb begin
    diff = {1'b0, dst_i} - {1'b0, src_i} - {8'h00, chain_i & carry_i};
    r    = diff[7:0];
    flags_o[CSBU_FLG_C] = (~dst_i[7] & src_i[7]) | (src_i[7] & r[7])
                        | (r[7] & ~dst_i[7]);
    flags_o[CSBU_FLG_H] = (~dst_i[3] & src_i[3]) | (src_i[3] & r[3])
                        | (r[3] & ~dst_i[3]);
    flags_o[CSBU_FLG_V] = (dst_i[7] & ~src_i[7] & ~r[7])
                        | (~dst_i[7] & src_i[7] & r[7]);
    flags_o[CSBU_FLG_N] = r[7];
    flags_o[CSBU_FLG_S] = r[7] ^ flags_o[CSBU_FLG_V];
    // with carry the zero flag may only fall, so chains stay correct
    flags_o[CSBU_FLG_Z] = (r == 8'h00) & (chain_i ? zero_i : 1'b1);
  end

endmodule // csbu_cmp_alu

`default_nettype wire

// *** verif/csbu_top_test.sv ***
// self-checking bench for the compare, skip and branch unit
// assumes csbu_pkg is compiled first; the bench is the axi master
`timescale 1ns/1ps
`default_nettype none

module csbu_top_test;
  import csbu_pkg::*;

  // ****************************************
  // signals
  // ****************************************
  logic        clock_i = 1'b0;
  logic        rst_i   = 1'b1;
  logic        awv     = 1'b0;
  logic        awr;
  logic [7:0]  awa     = 8'h00;
  logic        wv      = 1'b0;
  logic        wr_rdy;
  logic [31:0] wd      = 32'h0;
  logic [3:0]  ws      = 4'h0;
  logic        bv;
  logic        brd     = 1'b0;
  logic [1:0]  brs;
  logic        arv     = 1'b0;
  logic        arr;
  logic [7:0]  ara     = 8'h00;
  logic        rv;
  logic        rrd     = 1'b0;
  logic [31:0] rdat;
  logic [1:0]  rrs;
  logic [15:0] pc;
  logic [7:0]  flg;
  logic        busy;
  int          errors     = 0;
  int          n_compared = 0;

  // 100 MHz clock
  always #5 clock_i = ~clock_i;

  csbu_top i_csbu_top (
    .clock_i(clock_i), .rst_i(rst_i),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awa),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_rdy), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(ws), .s_axi_bvalid_o(bv), .s_axi_bready_i(brd),
    .s_axi_bresp_o(brs), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_araddr_i(ara), .s_axi_rvalid_o(rv), .s_axi_rready_i(rrd),
    .s_axi_rdata_o(rdat), .s_axi_rresp_o(rrs),
    .pc_o(pc), .flags_o(flg), .busy_o(busy)
  );

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic too_long();
    errors++;
    $display("BAD %0t wait ran out", $time);
    wrap_up();
  endtask

  // write; now skips the first edge so a write can follow back to back
  // valid lines drop once seen with ready, so no address or data is sent twice
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input bit now,
                    output logic [1:0] resp);
    if (!now) @(posedge clock_i);
    awv <= 1'b1;
    awa <= a;
    wv  <= 1'b1;
    wd  <= d;
    ws  <= s;
    brd <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge clock_i);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_rdy) wv <= 1'b0;
      if (bv) begin
        resp = brs;
        return;
      end
    end
    too_long();
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] resp);
    @(posedge clock_i);
    arv <= 1'b1;
    ara <= a;
    rrd <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge clock_i);
      if (arv && arr) arv <= 1'b0;
      if (rv) begin
        d    = rdat;
        resp = rrs;
        return;
      end
    end
    too_long();
  endtask

  // counts edges with busy high, starting one edge after the accepting edge, where wr returns
  task automatic wait_idle(output int c);
    c = 0;
    for (int n = 0; n < 20; n++) begin
      if (!busy) return;
      c++;
      @(posedge clock_i);
    end
    too_long();
  endtask

  // one instruction from pc 0x0100, then pc, flags, cycles and status
  task automatic exec(input logic [4:0] op, input logic [2:0] sel,
                      input logic [31:0] opd, input logic [7:0] f,
                      input logic [7:0] ef, input logic [15:0] epc,
                      input logic [1:0] ecyc);
    logic [1:0]  r;
    logic [31:0] st;
    int          c;
    wr(CSBU_OFS_OPERAND, opd, 4'hF, 1'b0, r);
    wr(CSBU_OFS_FLAGS, {24'h0, f}, 4'hF, 1'b0, r);
    wr(CSBU_OFS_PC, 32'h0000_0100, 4'hF, 1'b0, r);
    wr(CSBU_OFS_INSTR, {21'h0, sel, 3'h0, op}, 4'hF, 1'b0, r);
    wait_idle(c);
    check({16'h0, pc}, {16'h0, epc}, "pc");
    check({24'h0, flg}, {24'h0, ef}, "flags");
    check(32'(c), {30'h0, ecyc}, "busy cycles");
    rd(CSBU_OFS_STATUS, st, r);
    check({29'h0, st[3:1]}, {29'h0, ecyc, ecyc > 2'h1}, "status");
  endtask

  function automatic bit is_taken(input logic [4:0] op,
                                  input logic [2:0] s,
                                  input logic [7:0] f);
    case (op)
      5'h06:   return f[s];
      5'h07:   return !f[s];
      5'h08:   return f[CSBU_FLG_Z];
      5'h09:   return !f[CSBU_FLG_Z];
      5'h0A,
      5'h0D:   return f[CSBU_FLG_C];
      5'h0B,
      5'h0C:   return !f[CSBU_FLG_C];
      5'h0E:   return f[CSBU_FLG_N];
      5'h0F:   return !f[CSBU_FLG_N];
      5'h10:   return !(f[CSBU_FLG_N] ^ f[CSBU_FLG_V]);
      5'h11:   return f[CSBU_FLG_N] ^ f[CSBU_FLG_V];
      5'h12:   return f[CSBU_FLG_H];
      default: return !f[CSBU_FLG_H];
    endcase
  endfunction

  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_reset();
    logic [31:0] d;
    logic [1:0]  r;
    rd(CSBU_OFS_FLAGS, d, r);
    check(d, 32'h0, "flags reset");
    rd(CSBU_OFS_PC, d, r);
    check(d, 32'h0, "pc reset");
    $display("test reset done");
  endtask

  task automatic test_compare();
    exec(5'h00, 3'h0, 32'h2010, 8'hC0, 8'hD5, 16'h0101, 2'h1);
    exec(5'h00, 3'h0, 32'h0180, 8'h00, 8'h38, 16'h0101, 2'h1);
    exec(5'h01, 3'h0, 32'h0505, 8'h01, 8'h35, 16'h0101, 2'h1);
    exec(5'h01, 3'h0, 32'h0505, 8'h00, 8'h00, 16'h0101, 2'h1);
    exec(5'h01, 3'h0, 32'h0505, 8'h02, 8'h02, 16'h0101, 2'h1);
    $display("test compare done");
  endtask

  // source byte 0xA5 gives both bit values across the selects
  task automatic test_skip(input logic [4:0] op);
    bit         skip;
    logic [1:0] n;
    for (int s = 0; s < 4; s++) begin
      for (int two = 0; two < 2; two++) begin
        skip = (8'hA5 >> s) & 1;
        if (op == 5'h02 || op == 5'h04) skip = !skip;
        n = skip ? 2'(2 + two) : 2'h1;
        exec(op, 3'(s), {7'h0, 1'(two), 24'h00A500}, 8'h3F, 8'h3F,
             16'h0100 + 16'(n), n);
      end
    end
    $display("test skip %0h done", op);
  endtask

  // offsets include both ends of the signed range
  // selects step by two so the flag-select branches go both ways
  task automatic test_branch(input logic [4:0] lo, input logic [4:0] hi);
    logic [7:0] fl [4] = '{8'h00, 8'h3F, 8'h08, 8'h24};
    logic [6:0] ks [4] = '{7'h3F, 7'h40, 7'h7B, 7'h01};
    bit         t;
    for (logic [4:0] op = lo; op <= hi; op++) begin
      for (int j = 0; j < 4; j++) begin
        t = is_taken(op, 3'(op + 5'(2 * j)), fl[j]);
        exec(op, 3'(op + 5'(2 * j)), {9'h0, ks[j], 16'h0}, fl[j], fl[j],
             t ? 16'h0101 + {{9{ks[j][6]}}, ks[j]} : 16'h0101,
             t ? 2'h2 : 2'h1);
      end
    end
    $display("test branch %0h to %0h done", lo, hi);
  endtask

  task automatic test_refuse();
    logic [1:0]  r;
    logic [31:0] d;
    int          c;
    wr(CSBU_OFS_OPERAND, 32'h0100_0000, 4'hF, 1'b0, r);
    wr(CSBU_OFS_PC, 32'h0000_0100, 4'hF, 1'b0, r);
    wr(CSBU_OFS_INSTR, 32'h0000_0002, 4'hF, 1'b0, r);
    // write lands while the three-cycle skip still runs
    wr(CSBU_OFS_PC, 32'h0000_0055, 4'hF, 1'b1, r);
    check({30'h0, r}, {30'h0, CSBU_RESP_SLV}, "busy write");
    wait_idle(c);
    check({16'h0, pc}, 32'h0103, "pc after refusal");
    wr(8'h14, 32'h0, 4'hF, 1'b0, r);
    check({30'h0, r}, {30'h0, CSBU_RESP_SLV}, "unmapped write");
    wr(CSBU_OFS_STATUS, 32'h0, 4'hF, 1'b0, r);
    check({30'h0, r}, {30'h0, CSBU_RESP_SLV}, "status write");
    rd(8'h20, d, r);
    check({r, d[29:0]}, {CSBU_RESP_SLV, 30'h0}, "unmapped read");
    wr(CSBU_OFS_PC, 32'h0000_ABCD, 4'h2, 1'b0, r);
    rd(CSBU_OFS_PC, d, r);
    check(d, 32'h0000_AB03, "byte strobe");
    $display("test refuse done");
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    test_reset();
    test_compare();
    test_skip(5'h02);
    test_skip(5'h03);
    test_skip(5'h04);
    test_skip(5'h05);
    test_branch(5'h06, 5'h09);
    test_branch(5'h0A, 5'h0F);
    test_branch(5'h10, 5'h13);
    test_refuse();
    wrap_up();
  end

endmodule // csbu_top_test

`default_nettype wire
